// File: hw/idr_pkg.sv
// types shared by the identify responder.
// assumes idr_regs.svh is on the include path.
package idr_pkg;
    typedef enum logic [2:0] {
        IDR_IDLE = 3'b001,
        IDR_BUSY = 3'b010,
        IDR_XFER = 3'b100
    } idr_state_t;

    typedef struct packed {
        logic busy_flag;
        logic ready;
        logic device_fault;
        logic seek_complete;
        logic transfer_request;
        logic data_was_fixed;
        logic index_pulse;
        logic error;
    } idr_status_t;

    typedef struct packed {
        logic crc;
        logic media_read_failure;
        logic zero5;
        logic sector_not_located;
        logic zero3;
        logic command_aborted;
        logic track_zero_missing;
        logic address_mark_missing;
    } idr_error_t;

    typedef struct packed {
        logic spinup_needed;
        logic incomplete;
        logic security;
        logic [15:0] cylinders;
        logic [7:0]  heads;
        logic [7:0]  multi_max;
        logic [15:0] buf_size;
    } idr_cfg_t;
endpackage

// File: hw/idr_regs.svh
// register offsets, field positions, reset values and command codes of the
// identify responder; included by the responder module, the host model and the bench.
`ifndef IDR_REGS_SVH
`define IDR_REGS_SVH

`define IDR_OFS_DATA      12'h000
`define IDR_OFS_ERROR     12'h004
`define IDR_OFS_STATUS    12'h008
`define IDR_OFS_DEVHEAD   12'h00C
`define IDR_OFS_COMMAND   12'h010
`define IDR_OFS_CYLS      12'h014
`define IDR_OFS_GEOM      12'h018
`define IDR_OFS_OPTS      12'h01C
`define IDR_OFS_BUFSZ     12'h020
`define IDR_OFS_IRQ_STAT  12'h024
`define IDR_OFS_IRQ_MASK  12'h028
`define IDR_OFS_STR_BASE  12'h100
`define IDR_STR_WORDS     34

`define IDR_CMD_IDENTIFY  8'hEC
`define IDR_LAST_WORD     8'hFF

`define IDR_W0_COMPLETE   16'h045A
`define IDR_W0_INCOMPL    16'h045E
`define IDR_W2_NEED_INC   16'h37C8
`define IDR_W2_NEED_CMP   16'h738C
`define IDR_W2_NONE_INC   16'h8C73
`define IDR_W2_NONE_CMP   16'hC837
`define IDR_W6_SPT        16'h003F
`define IDR_W20_CTRL      16'h0003
`define IDR_W22_RSVD      16'h0038
`define IDR_W47_HIGH      8'h80
`define IDR_W48_BASE      16'h4000

`define IDR_RST_CYLS      16'h3FFF
`define IDR_RST_HEADS     8'h10
`define IDR_RST_MULTI     8'h10
`define IDR_RST_BUFSZ     16'h0000
`define IDR_RST_DEVHEAD   8'hA0

`define IDR_IRQ_DATA      0
`define IDR_IRQ_DONE      1
`define IDR_IRQ_ABORT     2
`define IDR_OPT_SPINUP    0
`define IDR_OPT_INCOMPL   1
`define IDR_OPT_SECURITY  2

`endif

// File: hw/idr_responder.sv
// identify-device command responder behind an APB register slave.
// assumes a single 20 MHz clock, APB master on the same clock, and
// software that drains the sector by reading the data register.
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "idr_regs.svh"

module idr_responder
    import idr_pkg::*;
(
    input  wire logic        CLK_I,
    input  wire logic        RESET_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [11:0] PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic             PREADY_O,
    output logic [31:0]      PRDATA_O,
    output logic             PSLVERR_O,
    output logic             IRQ_O
);

    ////////////////////////////////////////////////////////////////////////
    // state
    idr_state_t   state_ff;
    logic [7:0]   word_cnt_ff;
    logic         err_ff;
    logic         abort_ff;
    logic [7:0]   devhead_ff;
    idr_cfg_t     cfg_ff;
    logic [2:0]   irq_stat_ff;
    logic [2:0]   irq_mask_ff;
    logic [15:0]  str_mem [0:`IDR_STR_WORDS-1];
    logic         pready_ff;
    logic [31:0]  prdata_ff;
    logic         pslverr_ff;
    logic         irq_ff;

    logic         acc_first;
    logic         acc_done;
    logic         wr_done;
    logic         rd_done;
    logic         cmd_wr;
    logic         cmd_ok;
    logic         cmd_bad;
    logic         data_rd;
    logic         last_rd;
    logic         str_hit;
    logic [5:0]   str_sel;
    logic [31:0]  nxt_rdata;
    logic         nxt_slverr;
    logic [2:0]   irq_evt;
    idr_status_t  status;
    idr_error_t   error_reg;

    assign PREADY_O  = pready_ff;
    assign PRDATA_O  = prdata_ff;
    assign PSLVERR_O = pslverr_ff;
    assign IRQ_O     = irq_ff;

    ////////////////////////////////////////////////////////////////////////
    // identify sector word generator
    function automatic logic [5:0] str_slot(input logic [7:0] w);
        logic [7:0] s;
        s = 8'h00;
        if (w >= 8'd10 && w <= 8'd19) begin
            s = w - 8'd10;
        end else if (w >= 8'd23 && w <= 8'd46) begin
            s = w - 8'd13;
        end
        return s[5:0];
    endfunction

    function automatic logic [15:0] word_value(input logic [7:0] w,
                                               input idr_cfg_t   c,
                                               input logic [15:0] s);
        logic [15:0] v;
        v = 16'h0000;
        unique case (w)
            8'd0:  v = c.incomplete ? `IDR_W0_INCOMPL : `IDR_W0_COMPLETE;
            8'd1:  v = c.cylinders;
            8'd2: begin
                unique case ({c.spinup_needed, c.incomplete})
                    2'b11:   v = `IDR_W2_NEED_INC;
                    2'b10:   v = `IDR_W2_NEED_CMP;
                    2'b01:   v = `IDR_W2_NONE_INC;
                    default: v = `IDR_W2_NONE_CMP;
                endcase
            end
            8'd3:  v = {8'h00, c.heads};
            8'd6:  v = `IDR_W6_SPT;
            8'd7, 8'd8: v = 16'h0000;
            8'd20: v = `IDR_W20_CTRL;
            8'd21: v = c.buf_size;
            8'd22: v = `IDR_W22_RSVD;
            8'd47: v = {`IDR_W47_HIGH, c.multi_max};
            8'd48: v = `IDR_W48_BASE | {15'h0000, c.security};
            default: begin
                if ((w >= 8'd10 && w <= 8'd19) || (w >= 8'd23 && w <= 8'd46)) begin
                    v = s;
                end
            end
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // APB decode: answer comes one cycle into the access phase
    assign acc_first = PSEL_I && PENABLE_I && !pready_ff;
    assign acc_done  = PSEL_I && PENABLE_I && pready_ff;
    assign wr_done   = acc_done && PWRITE_I;
    assign rd_done   = acc_done && !PWRITE_I;
    assign cmd_wr    = wr_done && PADDR_I == `IDR_OFS_COMMAND && state_ff == IDR_IDLE;
    assign cmd_ok    = cmd_wr && PWDATA_I[7:0] == `IDR_CMD_IDENTIFY;
    assign cmd_bad   = cmd_wr && PWDATA_I[7:0] != `IDR_CMD_IDENTIFY;
    assign data_rd   = rd_done && PADDR_I == `IDR_OFS_DATA && state_ff == IDR_XFER;
    assign last_rd   = data_rd && word_cnt_ff == `IDR_LAST_WORD;
    assign str_hit   = PADDR_I >= `IDR_OFS_STR_BASE
                    && PADDR_I < `IDR_OFS_STR_BASE + 12'(4 * `IDR_STR_WORDS)
                    && PADDR_I[1:0] == 2'b00;
    assign str_sel   = 6'((PADDR_I - `IDR_OFS_STR_BASE) >> 2);

    always_comb begin
        status = '0;
        status.busy_flag        = state_ff == IDR_BUSY;
        status.ready            = 1'b1;
        status.seek_complete    = 1'b1;
        status.transfer_request = state_ff == IDR_XFER;
        status.error            = err_ff;
        error_reg = '0;
        error_reg.command_aborted = abort_ff;
    end

    always_comb begin
        nxt_rdata  = 32'h0000_0000;
        nxt_slverr = 1'b0;
        unique case (PADDR_I)
            `IDR_OFS_DATA: begin
                if (state_ff == IDR_XFER) begin
                    nxt_rdata[15:0] = word_value(word_cnt_ff, cfg_ff,
                                                 str_mem[str_slot(word_cnt_ff)]);
                end
            end
            `IDR_OFS_ERROR:    nxt_rdata[7:0]  = error_reg;
            `IDR_OFS_STATUS:   nxt_rdata[7:0]  = status;
            `IDR_OFS_DEVHEAD:  nxt_rdata[7:0]  = devhead_ff;
            `IDR_OFS_COMMAND:  nxt_rdata       = 32'h0000_0000;
            `IDR_OFS_CYLS:     nxt_rdata[15:0] = cfg_ff.cylinders;
            `IDR_OFS_GEOM:     nxt_rdata[15:0] = {cfg_ff.multi_max, cfg_ff.heads};
            `IDR_OFS_OPTS:     nxt_rdata[2:0]  = {cfg_ff.security, cfg_ff.incomplete,
                                                  cfg_ff.spinup_needed};
            `IDR_OFS_BUFSZ:    nxt_rdata[15:0] = cfg_ff.buf_size;
            `IDR_OFS_IRQ_STAT: nxt_rdata[2:0]  = irq_stat_ff;
            `IDR_OFS_IRQ_MASK: nxt_rdata[2:0]  = irq_mask_ff;
            default: begin
                if (str_hit) begin
                    nxt_rdata[15:0] = str_mem[str_sel];
                end else begin
                    nxt_slverr = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            pready_ff  <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff  <= acc_first;
            prdata_ff  <= acc_first && !PWRITE_I ? nxt_rdata : 32'h0000_0000;
            pslverr_ff <= acc_first && nxt_slverr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software-written configuration and strings
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            devhead_ff         <= `IDR_RST_DEVHEAD;
            cfg_ff.cylinders   <= `IDR_RST_CYLS;
            cfg_ff.heads       <= `IDR_RST_HEADS;
            cfg_ff.multi_max   <= `IDR_RST_MULTI;
            cfg_ff.buf_size    <= `IDR_RST_BUFSZ;
            cfg_ff.spinup_needed <= 1'b0;
            cfg_ff.incomplete  <= 1'b0;
            cfg_ff.security    <= 1'b0;
            irq_mask_ff        <= 3'h0;
        end else if (wr_done) begin
            unique case (PADDR_I)
                `IDR_OFS_DEVHEAD:  devhead_ff <= PWDATA_I[7:0];
                `IDR_OFS_CYLS:     cfg_ff.cylinders <= PWDATA_I[15:0];
                `IDR_OFS_GEOM: begin
                    cfg_ff.heads     <= PWDATA_I[7:0];
                    cfg_ff.multi_max <= PWDATA_I[15:8];
                end
                `IDR_OFS_OPTS: begin
                    cfg_ff.spinup_needed <= PWDATA_I[`IDR_OPT_SPINUP];
                    cfg_ff.incomplete    <= PWDATA_I[`IDR_OPT_INCOMPL];
                    cfg_ff.security      <= PWDATA_I[`IDR_OPT_SECURITY];
                end
                `IDR_OFS_BUFSZ:    cfg_ff.buf_size <= PWDATA_I[15:0];
                `IDR_OFS_IRQ_MASK: irq_mask_ff <= PWDATA_I[2:0];
                default: ;
            endcase
        end
    end

    // strings reset to zero, which reads as an unspecified serial
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            for (int i = 0; i < `IDR_STR_WORDS; i++) begin
                str_mem[i] <= 16'h0000;
            end
        end else if (wr_done && str_hit) begin
            str_mem[str_sel] <= PWDATA_I[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command sequencer
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            state_ff    <= IDR_IDLE;
            word_cnt_ff <= 8'h00;
        end else begin
            unique case (state_ff)
                IDR_IDLE: begin
                    word_cnt_ff <= 8'h00;
                    if (cmd_ok) begin
                        state_ff <= IDR_BUSY;
                    end
                end
                IDR_BUSY: state_ff <= IDR_XFER;
                IDR_XFER: begin
                    if (data_rd) begin
                        word_cnt_ff <= word_cnt_ff + 8'h01;
                    end
                    if (last_rd) begin
                        state_ff <= IDR_IDLE;
                    end
                end
                default: state_ff <= IDR_IDLE;
            endcase
        end
    end

    // error and abort reported without entering transfer
    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            err_ff   <= 1'b0;
            abort_ff <= 1'b0;
        end else if (cmd_bad) begin
            err_ff   <= 1'b1;
            abort_ff <= 1'b1;
        end else if (cmd_ok) begin
            err_ff   <= 1'b0;
            abort_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupts: sticky, cleared by reading, a new event wins the clear
    assign irq_evt = {cmd_bad, last_rd, state_ff == IDR_BUSY};

    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            irq_stat_ff <= 3'h0;
        end else if (rd_done && PADDR_I == `IDR_OFS_IRQ_STAT) begin
            irq_stat_ff <= irq_evt;
        end else begin
            irq_stat_ff <= irq_stat_ff | irq_evt;
        end
    end

    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions
    sequence s_cap(int n);
        acc_first && !PWRITE_I && PADDR_I == `IDR_OFS_DATA
            && state_ff == IDR_XFER && word_cnt_ff == 8'(n);
    endsequence

    property p_word(int n, logic [15:0] val);
        @(posedge CLK_I) disable iff (RESET_I)
        s_cap(n) |=> PRDATA_O[15:0] == val;
    endproperty

    a_cmd_accept: assert property (@(posedge CLK_I) disable iff (RESET_I)
        cmd_ok |=> state_ff == IDR_BUSY ##1 state_ff == IDR_XFER && word_cnt_ff == 8'h00)
        else $error("identify command not accepted");

    a_sector_end: assert property (@(posedge CLK_I) disable iff (RESET_I)
        data_rd |=> (state_ff == IDR_IDLE) == ($past(word_cnt_ff) == `IDR_LAST_WORD))
        else $error("sector length wrong");

    a_word0_class: assert property (@(posedge CLK_I) disable iff (RESET_I)
        s_cap(0) |=> PRDATA_O[15:0] == ($past(cfg_ff.incomplete) ?
                                         `IDR_W0_INCOMPL : `IDR_W0_COMPLETE))
        else $error("word 0 wrong");

    a_word2_spin: assert property (@(posedge CLK_I) disable iff (RESET_I)
        s_cap(2) && !cfg_ff.spinup_needed && !cfg_ff.incomplete
            |=> PRDATA_O[15:0] == `IDR_W2_NONE_CMP)
        else $error("word 2 wrong");

    a_word6_spt: assert property (p_word(6, `IDR_W6_SPT))
        else $error("word 6 wrong");

    a_word7_gap: assert property (p_word(7, 16'h0000))
        else $error("word 7 not zero");

    a_word20_ctrl: assert property (p_word(20, `IDR_W20_CTRL))
        else $error("word 20 wrong");

    a_word47_multi: assert property (@(posedge CLK_I) disable iff (RESET_I)
        s_cap(47) |=> PRDATA_O[15:8] == `IDR_W47_HIGH
                   && PRDATA_O[7:0] == $past(cfg_ff.multi_max))
        else $error("word 47 wrong");

    a_word48_sec: assert property (@(posedge CLK_I) disable iff (RESET_I)
        s_cap(48) |=> PRDATA_O[15:1] == 15'h2000 && PRDATA_O[0] == $past(cfg_ff.security))
        else $error("word 48 wrong");

    a_word9_rsvd: assert property (p_word(9, 16'h0000))
        else $error("reserved word not zero");

    a_abort_flags: assert property (@(posedge CLK_I) disable iff (RESET_I)
        cmd_bad |=> err_ff && abort_ff && state_ff == IDR_IDLE [*2])
        else $error("abort not reported");

    a_word2_codes: assert property (@(posedge CLK_I) disable iff (RESET_I)
        s_cap(2) |=> PRDATA_O[15:0] == ($past(cfg_ff.spinup_needed) ?
            ($past(cfg_ff.incomplete) ? `IDR_W2_NEED_INC : `IDR_W2_NEED_CMP) :
            ($past(cfg_ff.incomplete) ? `IDR_W2_NONE_INC : `IDR_W2_NONE_CMP)))
        else $error("word 2 code wrong");

    a_word1_cyls: assert property (@(posedge CLK_I) disable iff (RESET_I)
        s_cap(1) |=> PRDATA_O[15:0] == $past(cfg_ff.cylinders))
        else $error("word 1 wrong");

    a_word3_heads: assert property (@(posedge CLK_I) disable iff (RESET_I)
        s_cap(3) |=> PRDATA_O[15:0] == {8'h00, $past(cfg_ff.heads)})
        else $error("word 3 wrong");

    a_word8_sync: assert property (p_word(8, 16'h0000))
        else $error("word 8 not zero");

    a_serial_first: assert property (@(posedge CLK_I) disable iff (RESET_I)
        s_cap(10) |=> PRDATA_O[15:0] == $past(str_mem[0]))
        else $error("serial word wrong");

    a_firmware_first: assert property (@(posedge CLK_I) disable iff (RESET_I)
        s_cap(23) |=> PRDATA_O[15:0] == $past(str_mem[10]))
        else $error("firmware word wrong");

    a_model_last: assert property (@(posedge CLK_I) disable iff (RESET_I)
        s_cap(46) |=> PRDATA_O[15:0] == $past(str_mem[33]))
        else $error("model word wrong");

    a_word21_buf: assert property (@(posedge CLK_I) disable iff (RESET_I)
        s_cap(21) |=> PRDATA_O[15:0] == $past(cfg_ff.buf_size))
        else $error("word 21 wrong");

    a_word4_rsvd: assert property (p_word(4, 16'h0000))
        else $error("word 4 not zero");

    a_word5_rsvd: assert property (p_word(5, 16'h0000))
        else $error("word 5 not zero");

endmodule

// File: tb/idr_host_model.sv
// host controller model: an apb master that issues task-file commands.
// assumes one clock shared with the responder; the bench calls its tasks.
`timescale 1ns/1ps
`include "idr_regs.svh"

module idr_host_model (
    input  wire logic        clk_i,
    input  wire logic        pready_i,
    input  wire logic [31:0] prdata_i,
    input  wire logic        pslverr_i,
    output logic             psel_o,
    output logic             penable_o,
    output logic             pwrite_o,
    output logic [11:0]      paddr_o,
    output logic [31:0]      pwdata_o
);
    int gap = 0;

    initial begin
        psel_o <= 1'h0;
        penable_o <= 1'h0;
        pwrite_o <= 1'h0;
        paddr_o <= 12'h000;
        pwdata_o <= 32'h0000_0000;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one transfer, held until pready is seen high at a rising edge
    task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic err);
        repeat (gap + 1) @(posedge clk_i);
        psel_o <= 1'h1;
        penable_o <= 1'h0;
        pwrite_o <= wr;
        paddr_o <= addr;
        pwdata_o <= wdata;
        @(posedge clk_i);
        penable_o <= 1'h1;
        do @(posedge clk_i); while (pready_i !== 1'h1);
        rdata = prdata_i;
        err = pslverr_i;
        psel_o <= 1'h0;
        penable_o <= 1'h0;
        // released lines carry the inverse so stale values never pass for data
        pwrite_o <= ~wr;
        paddr_o <= ~addr;
        pwdata_o <= ~wdata;
    endtask

    // command register write that starts a command
    task automatic issue(input logic [7:0] code);
        logic [31:0] r;
        logic        e;
        xfer(1'h1, `IDR_OFS_COMMAND, {24'h00_0000, code}, r, e);
    endtask
endmodule

// File: tb/idr_responder_tb.sv
// self-checking bench for the identify responder.
// assumes idr_regs.svh on the include path and the host model beside it.
`timescale 1ns/1ps
`include "idr_regs.svh"

module idr_responder_tb
    import idr_pkg::*;
;
    logic        clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        irq;
    logic [15:0] str_mem [34];
    int          err_count = 0;
    int          checked = 0;
    int          cycles = 0;

    idr_responder i_idr_responder (.CLK_I(clk), .RESET_I(rst), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PREADY_O(pready), .PRDATA_O(prdata), .PSLVERR_O(pslverr), .IRQ_O(irq));

    idr_host_model i_host (.clk_i(clk), .pready_i(pready), .prdata_i(prdata),
        .pslverr_i(pslverr), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
        .paddr_o(paddr), .pwdata_o(pwdata));

    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        if (err_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        logic e;
        i_host.xfer(1'h0, a, 32'h0000_0000, d, e);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        i_host.xfer(1'h1, a, d, r, e);
    endtask

    task automatic chk(input logic [11:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        rd(a, d);
        cmp32(d, exp, what);
    endtask

    function automatic logic [15:0] exp_word(input idr_cfg_t c, input int w);
        case (w)
            0: return c.incomplete ? 16'h045E : 16'h045A;
            1: return c.cylinders;
            2: return c.spinup_needed ? (c.incomplete ? 16'h37C8 : 16'h738C)
                                      : (c.incomplete ? 16'h8C73 : 16'hC837);
            3: return {8'h00, c.heads};
            6: return 16'h003F;
            20: return 16'h0003;
            21: return c.buf_size;
            22: return 16'h0038;
            47: return {8'h80, c.multi_max};
            48: return {15'h2000, c.security};
            default: ;
        endcase
        if (w >= 10 && w <= 19) return str_mem[w - 10];
        if (w >= 23 && w <= 46) return str_mem[w - 13];
        return 16'h0000;
    endfunction

    task automatic set_cfg(input idr_cfg_t c);
        wr(`IDR_OFS_CYLS, {16'h0000, c.cylinders});
        wr(`IDR_OFS_GEOM, {16'h0000, c.multi_max, c.heads});
        wr(`IDR_OFS_OPTS, {29'h0, c.security, c.incomplete, c.spinup_needed});
        wr(`IDR_OFS_BUFSZ, {16'h0000, c.buf_size});
        for (int i = 0; i < 34; i++) wr(`IDR_OFS_STR_BASE + 12'(4 * i), {16'h0000, str_mem[i]});
    endtask

    // full identify; intrude writes another command in mid-transfer
    task automatic run_identify(input idr_cfg_t c, input logic intrude);
        logic [31:0] d;
        int          n;
        set_cfg(c);
        i_host.issue(8'hEC);
        n = 0;
        do begin
            rd(`IDR_OFS_STATUS, d);
            n++;
        end while (d[3] !== 1'h1 && n < 20);
        cmp32(d, 32'h0000_0058, "status with data ready");
        cmp32({31'h0, irq}, 32'h0000_0001, "irq on data ready");
        for (int w = 0; w < 256; w++) begin
            if (intrude && w == 10) i_host.issue(8'h50);
            rd(`IDR_OFS_DATA, d);
            cmp32(d, {16'h0000, exp_word(c, w)}, "sector word");
        end
        chk(`IDR_OFS_STATUS, 32'h0000_0050, "idle after sector");
        chk(`IDR_OFS_DATA, 32'h0000_0000, "word past sector");
        chk(`IDR_OFS_ERROR, 32'h0000_0000, "error clear");
        chk(`IDR_OFS_IRQ_STAT, 32'h0000_0003, "irq events");
        chk(`IDR_OFS_IRQ_STAT, 32'h0000_0000, "irq read clears");
        cmp32({31'h0, irq}, 32'h0000_0000, "irq low");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_values();
        logic [31:0] d;
        logic        e;
        chk(`IDR_OFS_DEVHEAD, 32'h0000_00A0, "head select reset");
        chk(`IDR_OFS_CYLS, 32'h0000_3FFF, "cylinders reset");
        chk(`IDR_OFS_GEOM, 32'h0000_1010, "geometry reset");
        chk(`IDR_OFS_OPTS, 32'h0000_0000, "options reset");
        chk(`IDR_OFS_BUFSZ, 32'h0000_0000, "buffer size reset");
        chk(`IDR_OFS_STATUS, 32'h0000_0050, "status reset");
        chk(`IDR_OFS_ERROR, 32'h0000_0000, "error reset");
        chk(`IDR_OFS_IRQ_MASK, 32'h0000_0000, "mask reset");
        chk(`IDR_OFS_COMMAND, 32'h0000_0000, "command reads zero");
        wr(`IDR_OFS_DEVHEAD, 32'hFFFF_FFB5);
        chk(`IDR_OFS_DEVHEAD, 32'h0000_00B5, "head select write");
        i_host.xfer(1'h0, 12'h3FC, 32'h0000_0000, d, e);
        cmp32({e, d[30:0]}, 32'h8000_0000, "unmapped read");
    endtask

    task automatic t_abort_mask();
        logic [7:0] codes [4] = '{8'h00, 8'h50, 8'hED, 8'hFF};
        wr(`IDR_OFS_IRQ_MASK, 32'h0000_0000);
        foreach (codes[k]) begin
            i_host.issue(codes[k]);
            chk(`IDR_OFS_ERROR, 32'h0000_0004, "abort bit");
            chk(`IDR_OFS_STATUS, 32'h0000_0051, "error status");
            chk(`IDR_OFS_DATA, 32'h0000_0000, "no data on abort");
            cmp32({31'h0, irq}, 32'h0000_0000, "masked irq");
        end
        wr(`IDR_OFS_IRQ_MASK, 32'h0000_0004);
        repeat (2) @(posedge clk);
        cmp32({31'h0, irq}, 32'h0000_0001, "unmasked abort irq");
        chk(`IDR_OFS_IRQ_STAT, 32'h0000_0004, "abort event");
        repeat (2) @(posedge clk);
        cmp32({31'h0, irq}, 32'h0000_0000, "irq after clear");
        wr(`IDR_OFS_IRQ_MASK, 32'h0000_0007);
    endtask

    task automatic t_identify_all();
        idr_cfg_t c;
        foreach (str_mem[k]) str_mem[k] = 16'h0000;
        for (int i = 0; i < 4; i++) begin
            c.spinup_needed = i[0];
            c.incomplete = i[1];
            c.security = i[0] ^ i[1];
            c.cylinders = 16'h3FFF - 16'(i);
            c.heads = 8'h0F + 8'(i);
            c.multi_max = 8'h10 << i;
            c.buf_size = 16'h0800 * 16'(i);
            run_identify(c, 1'h0);
            for (int k = 0; k < 34; k++) str_mem[k] = {8'h41 + 8'(k), 8'h30 + 8'(i)};
        end
        i_host.gap = 3;
        run_identify(c, 1'h1);
    endtask

    initial begin
        rst <= 1'h1;
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        t_reset_values();
        t_abort_mask();
        t_identify_all();
        final_report();
    end
endmodule
